/* File: hdl/cssel_pkg.sv */
package cssel_pkg;
   // switch bus codes shared by both selectors
   localparam logic [1:0] CSSEL_BUS_PHY_INV = 2'h0;
   localparam logic [1:0] CSSEL_BUS_RCV     = 2'h1;
   localparam logic [1:0] CSSEL_BUS_AREQ    = 2'h2;
   localparam logic [1:0] CSSEL_BUS_BREQ    = 2'h3;
   // configuration byte field positions
   localparam int CSSEL_SEC_SEL_LO_POS = 2;
   localparam int CSSEL_SEC_SEL_HI_POS = 3;
   localparam int CSSEL_TX_SEL_LO_POS  = 4;
   localparam int CSSEL_TX_SEL_HI_POS  = 5;
   localparam int CSSEL_PRI_EN_POS     = 6;
   localparam int CSSEL_SEC_EN_POS     = 7;
   localparam logic [7:0] CSSEL_CFG_RST    = 8'h00;
   // transmit mode code for active transmit
   localparam logic [2:0] CSSEL_TM_ACTIVE  = 3'h0;
   // symbol bus width: parity, control, eight data
   localparam int CSSEL_BUS_W = 10;
   // halt pairs sent before idle in repeat of an invalid bus
   localparam logic [3:0] CSSEL_HALT_PAIRS = 4'h8;
   localparam logic [4:0] CSSEL_SYM_HALT   = 5'h04;
   localparam logic [4:0] CSSEL_SYM_IDLE   = 5'h1f;
endpackage

/* File: hdl/cssel_mux4.sv */
`timescale 1ns/10ps
module cssel_mux4
   import cssel_pkg::*;
(
   // select and buses
   input  wire logic [1:0]            sel,
   input  wire logic [CSSEL_BUS_W-1:0] bus_phy_inv,
   input  wire logic [CSSEL_BUS_W-1:0] bus_rcv,
   input  wire logic [CSSEL_BUS_W-1:0] bus_areq,
   input  wire logic [CSSEL_BUS_W-1:0] bus_breq,
   // chosen bus
   output logic      [CSSEL_BUS_W-1:0] bus_out
);
   always_comb begin
      unique case (sel)
         CSSEL_BUS_PHY_INV: bus_out = bus_phy_inv;
         CSSEL_BUS_RCV:     bus_out = bus_rcv;
         CSSEL_BUS_AREQ:    bus_out = bus_areq;
         CSSEL_BUS_BREQ:    bus_out = bus_breq;
      endcase
   end
endmodule

/* File: hdl/cssel_switch.sv */
`timescale 1ns/10ps
module cssel_switch
   import cssel_pkg::*;
#(
   parameter bit HAS_SEC_PORT = 1'b1
)
(
   // clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   nrst,
   // configuration write and readback port, transmit mode
   input  wire logic                   cfg_wr,
   input  wire logic [7:0]             cfg_wdata,
   output logic      [7:0]             cfg_rdata,
   input  wire logic [2:0]             tx_mode_field,
   // switch buses {parity, control, data}
   input  wire logic [CSSEL_BUS_W-1:0] bus_phy_inv,
   input  wire logic [CSSEL_BUS_W-1:0] bus_rcv,
   input  wire logic [CSSEL_BUS_W-1:0] bus_areq,
   input  wire logic [CSSEL_BUS_W-1:0] bus_breq,
   // primary indicate port
   output logic                        pri_ind_parity,
   output logic                        pri_ind_control,
   output logic      [7:0]             pri_ind_data,
   output logic                        pri_ind_oe,
   // secondary indicate port
   output logic                        sec_ind_parity,
   output logic                        sec_ind_control,
   output logic      [7:0]             sec_ind_data,
   output logic                        sec_ind_oe,
   // transmitter side
   output logic      [CSSEL_BUS_W-1:0] tx_bus,
   output logic                        tx_repeat_fill,
   output logic      [4:0]             tx_fill_sym
);
   // configuration
   logic [7:0]             cfg;
   logic [7:0]             next_cfg;
   logic [1:0]             sec_sel;
   logic [1:0]             tx_sel;
   // primary indicate port
   logic [CSSEL_BUS_W-1:0] pri_q;
   logic [CSSEL_BUS_W-1:0] next_pri;
   logic                   next_pri_oe;
   // secondary indicate port
   logic [CSSEL_BUS_W-1:0] sec_sel_bus;
   logic [CSSEL_BUS_W-1:0] sec_q;
   logic [CSSEL_BUS_W-1:0] next_sec;
   logic                   next_sec_oe;
   // transmitter input and repeat fill
   logic [CSSEL_BUS_W-1:0] tx_sel_bus;
   logic [CSSEL_BUS_W-1:0] next_tx;
   logic                   fill_cond;
   logic [3:0]             halt_cnt;
   logic [3:0]             next_halt_cnt;
   logic                   next_fill;
   logic [4:0]             next_fill_sym;

   typedef enum logic [1:0] {
      CSSEL_RF_PASS,
      CSSEL_RF_HALT,
      CSSEL_RF_IDLE
   } cssel_rf_t;

   cssel_rf_t              rf_state;
   cssel_rf_t              next_rf_state;

   function automatic logic [1:0] sel_field(
      input logic [7:0] cfg_byte,
      input int         lo_pos,
      input int         hi_pos
   );
      sel_field = {cfg_byte[hi_pos], cfg_byte[lo_pos]};
   endfunction

   always_comb begin
      next_cfg = cfg;
      if (cfg_wr) begin
         next_cfg = cfg_wdata;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cfg <= CSSEL_CFG_RST;
      end else begin
         cfg <= next_cfg;
      end
   end

   assign sec_sel = sel_field(cfg, CSSEL_SEC_SEL_LO_POS, CSSEL_SEC_SEL_HI_POS);
   assign tx_sel  = sel_field(cfg, CSSEL_TX_SEL_LO_POS, CSSEL_TX_SEL_HI_POS);
   // bits always stored and read back, even with no secondary port
   assign cfg_rdata = cfg;

   cssel_mux4 u_sec_mux (
      .sel         (sec_sel),
      .bus_phy_inv (bus_phy_inv),
      .bus_rcv     (bus_rcv),
      .bus_areq    (bus_areq),
      .bus_breq    (bus_breq),
      .bus_out     (sec_sel_bus)
   );

   cssel_mux4 u_tx_mux (
      .sel         (tx_sel),
      .bus_phy_inv (bus_phy_inv),
      .bus_rcv     (bus_rcv),
      .bus_areq    (bus_areq),
      .bus_breq    (bus_breq),
      .bus_out     (tx_sel_bus)
   );

   // primary source is fixed to the receiver here; its selector is outside this block
   always_comb begin
      next_pri    = bus_rcv;
      next_pri_oe = cfg[CSSEL_PRI_EN_POS];
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pri_q      <= '0;
         pri_ind_oe <= 1'b0;
      end else begin
         pri_q      <= next_pri;
         pri_ind_oe <= next_pri_oe;
      end
   end

   // a missing secondary port keeps its pins quiet, whatever the bits say
   always_comb begin
      next_sec    = HAS_SEC_PORT ? sec_sel_bus : '0;
      next_sec_oe = HAS_SEC_PORT && cfg[CSSEL_SEC_EN_POS];
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sec_q      <= '0;
         sec_ind_oe <= 1'b0;
      end else begin
         sec_q      <= next_sec;
         sec_ind_oe <= next_sec_oe;
      end
   end

   always_comb begin
      next_tx = tx_sel_bus;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tx_bus <= '0;
      end else begin
         tx_bus <= next_tx;
      end
   end

   // fill only while active transmit repeats the phy-invalid bus
   assign fill_cond = (tx_mode_field == CSSEL_TM_ACTIVE)
                      && (tx_sel == CSSEL_BUS_PHY_INV);

   // one count per halt pair; idle then holds until the condition drops
   always_comb begin
      next_rf_state = rf_state;
      next_halt_cnt = halt_cnt;
      if (!fill_cond) begin
         next_rf_state = CSSEL_RF_PASS;
         next_halt_cnt = '0;
      end else begin
         unique case (rf_state)
            CSSEL_RF_PASS: begin
               next_rf_state = CSSEL_RF_HALT;
               next_halt_cnt = '0;
            end
            CSSEL_RF_HALT: begin
               if (halt_cnt == CSSEL_HALT_PAIRS - 4'h1) begin
                  next_rf_state = CSSEL_RF_IDLE;
               end else begin
                  next_halt_cnt = halt_cnt + 4'h1;
               end
            end
            CSSEL_RF_IDLE: begin
               next_rf_state = CSSEL_RF_IDLE;
            end
            // fourth code is unused; fall back to pass-through
            default: begin
               next_rf_state = CSSEL_RF_PASS;
            end
         endcase
      end
      next_fill     = next_rf_state != CSSEL_RF_PASS;
      next_fill_sym = (next_rf_state == CSSEL_RF_HALT) ? CSSEL_SYM_HALT : CSSEL_SYM_IDLE;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rf_state       <= CSSEL_RF_PASS;
         halt_cnt       <= '0;
         tx_repeat_fill <= 1'b0;
         tx_fill_sym    <= CSSEL_SYM_IDLE;
      end else begin
         rf_state       <= next_rf_state;
         halt_cnt       <= next_halt_cnt;
         tx_repeat_fill <= next_fill;
         tx_fill_sym    <= next_fill_sym;
      end
   end

   // bit order {parity, control, data[7:0]}
   assign pri_ind_parity  = pri_q[9];
   assign pri_ind_control = pri_q[8];
   assign pri_ind_data    = pri_q[7:0];

   assign sec_ind_parity  = sec_q[9];
   assign sec_ind_control = sec_q[8];
   assign sec_ind_data    = sec_q[7:0];
endmodule

/* File: testbench/cssel_switch_chk.sv */
`timescale 1ns/10ps
module cssel_switch_chk
   import cssel_pkg::*;
#(parameter bit HAS_SEC_PORT = 1'b1)
(
   input wire logic core_clk, nrst, cfg_wr, pri_ind_parity, pri_ind_control, pri_ind_oe,
   input wire logic sec_ind_parity, sec_ind_control, sec_ind_oe, tx_repeat_fill,
   input wire logic [7:0] cfg_wdata, cfg_rdata, pri_ind_data, sec_ind_data,
   input wire logic [2:0] tx_mode_field,
   input wire logic [4:0] tx_fill_sym,
   input wire logic [CSSEL_BUS_W-1:0] bus_phy_inv, bus_rcv, bus_areq, bus_breq, tx_bus
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   function automatic logic [9:0] pick(logic [1:0] s, logic [9:0] a, b, c, d);
      return s == 2'h0 ? a : s == 2'h1 ? b : s == 2'h2 ? c : d;
   endfunction
   wire [9:0] sec = {sec_ind_parity, sec_ind_control, sec_ind_data};
   wire [9:0] pri = {pri_ind_parity, pri_ind_control, pri_ind_data};
   wire act = tx_mode_field == CSSEL_TM_ACTIVE && cfg_rdata[5:4] == CSSEL_BUS_PHY_INV;
   // eight halt pairs, then idle
   sequence halt_run;
      (tx_repeat_fill && tx_fill_sym == CSSEL_SYM_HALT) [*8];
   endsequence
   sequence idle_on;
      tx_repeat_fill && tx_fill_sym == CSSEL_SYM_IDLE;
   endsequence
   chk_sec_source: assert property ($past(nrst) && sec_ind_oe |-> sec == pick(
      $past(cfg_rdata[3:2]),
      $past(bus_phy_inv), $past(bus_rcv), $past(bus_areq), $past(bus_breq)))
      else $error("secondary port source wrong");
   chk_tx_source: assert property ($past(nrst) |-> tx_bus == pick($past(cfg_rdata[5:4]),
      $past(bus_phy_inv), $past(bus_rcv), $past(bus_areq), $past(bus_breq)))
      else $error("transmit source wrong");
   chk_fill_order: assert property ($rose(act) |=> halt_run ##1 idle_on)
      else $error("halt then idle fill missing");
   chk_pri_drive: assert property ($past(nrst) |-> pri_ind_oe == $past(cfg_rdata[6])
      && pri == $past(bus_rcv)) else $error("primary port drive wrong");
   chk_sec_enable: assert property ($past(nrst) |-> sec_ind_oe == (HAS_SEC_PORT
      && $past(cfg_rdata[7]))) else $error("secondary enable wrong");
   chk_cfg_keep: assert property ($past(nrst) && $past(cfg_wr) |->
      cfg_rdata == $past(cfg_wdata))
      else $error("config readback wrong");
endmodule
bind cssel_switch cssel_switch_chk #(.HAS_SEC_PORT(HAS_SEC_PORT)) i_cssel_switch_chk (
   .core_clk        (core_clk),
   .nrst            (nrst),
   .cfg_wr          (cfg_wr),
   .pri_ind_parity  (pri_ind_parity),
   .pri_ind_control (pri_ind_control),
   .pri_ind_oe      (pri_ind_oe),
   .sec_ind_parity  (sec_ind_parity),
   .sec_ind_control (sec_ind_control),
   .sec_ind_oe      (sec_ind_oe),
   .tx_repeat_fill  (tx_repeat_fill),
   .cfg_wdata       (cfg_wdata),
   .cfg_rdata       (cfg_rdata),
   .pri_ind_data    (pri_ind_data),
   .sec_ind_data    (sec_ind_data),
   .tx_mode_field   (tx_mode_field),
   .tx_fill_sym     (tx_fill_sym),
   .bus_phy_inv     (bus_phy_inv),
   .bus_rcv         (bus_rcv),
   .bus_areq        (bus_areq),
   .bus_breq        (bus_breq),
   .tx_bus          (tx_bus)
);

/* File: testbench/cssel_mac_model.sv */
`timescale 1ns/10ps
module cssel_mac_model
   import cssel_pkg::*;
(
   input  wire logic                   core_clk,
   output logic      [CSSEL_BUS_W-1:0] areq,
   output logic      [CSSEL_BUS_W-1:0] breq
);
   // request buses move every symbol so a stale pick shows
   initial begin
      areq = 10'h2a5;
      breq = 10'h15a;
   end
   always @(posedge core_clk) begin
      #1;
      areq <= areq + 10'h001;
      breq <= breq - 10'h003;
   end
endmodule

/* File: testbench/cssel_switch_bench.sv */
`timescale 1ns/10ps
module cssel_switch_bench import cssel_pkg::*;;
   logic core_clk = 0, nrst = 0, cfg_wr = 0, pp, pc, po, sp, sc, so, fill;
   logic [7:0] cfg_wdata = 8'h00, cfg_rdata, pd, sd;
   logic [2:0] tm = 3'h1;
   logic [9:0] phy = 10'h0c3, rcv = 10'h33c, areq, breq, tx_bus, es;
   logic [4:0] sym;
   int fails = 0, num_checks = 0, cyc = 0;
   cssel_switch i_cssel_switch (.core_clk, .nrst, .cfg_wr, .cfg_wdata, .cfg_rdata,
      .tx_mode_field(tm), .bus_phy_inv(phy), .bus_rcv(rcv), .bus_areq(areq), .bus_breq(breq),
      .pri_ind_parity(pp), .pri_ind_control(pc), .pri_ind_data(pd), .pri_ind_oe(po),
      .sec_ind_parity(sp), .sec_ind_control(sc), .sec_ind_data(sd), .sec_ind_oe(so),
      .tx_bus, .tx_repeat_fill(fill), .tx_fill_sym(sym));
   cssel_mac_model i_cssel_mac_model (.core_clk, .areq, .breq);
   initial forever #2 core_clk = ~core_clk;
   function automatic logic [9:0] pick(logic [1:0] s);
      return s == 2'h0 ? phy : s == 2'h1 ? rcv : s == 2'h2 ? areq : breq;
   endfunction
   task cmp(input string n, input logic [9:0] e, g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   task wcfg(input logic [7:0] v);
      cfg_wr = 1;
      cfg_wdata = v;
      @(posedge core_clk) #1 cfg_wr = 0;
   endtask
   task t_route;
      for (int s = 0; s < 4; s++) begin
         wcfg({2'b11, s[1:0], s[1:0], 2'b01});
         // request buses move just after each edge; take what the next edge samples
         @(negedge core_clk) es = pick(s[1:0]);
         @(posedge core_clk) #1;
         cmp("sec", es, {sp, sc, sd});
         cmp("tx", es, tx_bus);
         cmp("pri", rcv, {pp, pc, pd});
         cmp("oe", 2'b11, {po, so});
      end
      $display("route done");
   endtask
   task t_enable;
      wcfg(8'h40);
      @(posedge core_clk) #1 cmp("oe", 2'b10, {po, so});
      wcfg(8'h80);
      @(posedge core_clk) #1 cmp("oe", 2'b01, {po, so});
      cmp("rd", 8'h80, cfg_rdata);
      $display("enable done");
   endtask
   task t_fill;
      int n;
      wcfg(8'h00);
      tm = CSSEL_TM_ACTIVE;
      @(posedge core_clk) #1 cmp("halt", {1'b1, CSSEL_SYM_HALT}, {fill, sym});
      n = 1;
      repeat (11) begin
         @(posedge core_clk) #1;
         if (fill === 1'b1 && sym === CSSEL_SYM_HALT) begin
            n++;
         end
      end
      cmp("pairs", CSSEL_HALT_PAIRS, n[9:0]);
      cmp("idle", {1'b1, CSSEL_SYM_IDLE}, {fill, sym});
      tm = 3'h1;
      $display("fill done");
   endtask
   task t_reset;
      nrst = 0;
      #1 cmp("rst oe", 10'h000, {po, so});
      cmp("rst rd", 10'h000, cfg_rdata);
      cmp("rst fill", {1'b0, CSSEL_SYM_IDLE}, {fill, sym});
      @(posedge core_clk) #1 nrst = 1;
      wcfg(8'h5c);
      @(posedge core_clk) #1 cmp("rd", 10'h05c, cfg_rdata);
      $display("reset done");
   endtask
   task summarize;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // hang guard well past the few dozen cycles used
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         summarize();
      end
   end
   initial begin
      repeat (2) @(posedge core_clk);
      #1 nrst = 1;
      t_route();
      t_enable();
      t_fill();
      t_reset();
      summarize();
   end
endmodule
